/* inc/osc_select_map.vh */
// Register map, field layout, reset values and timing for the system oscillator select block
//
// Summary of operation
// - Reset selects secondary oscillator without software
// - Code 0 routes secondary oscillator, enable/ready
// - Code 4 routes primary oscillator, enable/ready
// - Lowpower-off bit stops primary in low power
// - Nano-ring oscillator always runs, never disabled
// - Nano-ring rate field, resets to 30kHz
// - Code 3 routes nano-ring oscillator
// - Code 5 routes baud oscillator, no enable
// - Code 1 routes PLL; enable, lock ready
// - PLL enable also starts base oscillator
// - PLL double-rate output for accelerator clock
// - Code 2 routes external base oscillator
// - Code 6 routes RTC oscillator, enable/ready
// - RTC enabled forces RTC oscillator on
// - Reset leaves RTC oscillator disabled
// - Select write clears done; set after switch
// - Divider field divides by two to field
// - Bus clock equals system, peripheral half
// - Soft/peripheral reset keeps enables and select
`ifndef OSC_SELECT_MAP_VH
`define OSC_SELECT_MAP_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define OSC_REG_CLKCTRL      4'h0
`define OSC_REG_PLLCTRL      4'h4
`define OSC_REG_PMCTRL       4'h8
`define OSC_REG_NROCTRL      4'hC

// ****************************************************************
// Clock, PLL, power-management and nano-ring rate control fields
// ****************************************************************
`define CLK_SEL_LSB          0
`define CLK_DIV_LSB          3
`define CLK_DONE_BIT         6
`define CLK_ISO_EN_BIT       16
`define CLK_IPO_EN_BIT       17
`define CLK_EBO_EN_BIT       18
`define CLK_RTCO_EN_BIT      19
`define CLK_ISO_RDY_BIT      24
`define CLK_IPO_RDY_BIT      25
`define CLK_EBO_RDY_BIT      26
`define CLK_RTCO_RDY_BIT     27
`define CLK_NRO_RDY_BIT      28
`define CLK_BRO_RDY_BIT      29
`define PLL_EN_BIT           0
`define PLL_DBL_SEL_BIT      1
`define PLL_RDY_BIT          8
`define PM_IPO_OFF_BIT       0
`define NRO_FREQ_LSB         0

// ****************************************************************
// Select codes and rate codes
// ****************************************************************
`define SEL_ISO              3'h0
`define SEL_PLL              3'h1
`define SEL_EBO              3'h2
`define SEL_NRO              3'h3
`define SEL_IPO              3'h4
`define SEL_BRO              3'h5
`define SEL_RTCO             3'h6
`define SEL_PIN              3'h7
`define NRO_FREQ_8K          2'h0
`define NRO_FREQ_16K         2'h1
`define NRO_FREQ_30K         2'h2

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_SEL              `SEL_ISO
`define RST_DIV              3'h0
`define RST_NRO_FREQ         `NRO_FREQ_30K

// ****************************************************************
// Timing
// ****************************************************************
`define REF_CLK_PERIOD_NS    25
`define OSC_SETTLE_NS        100
`define OSC_SETTLE_CYC       ((`OSC_SETTLE_NS + `REF_CLK_PERIOD_NS - 1) / `REF_CLK_PERIOD_NS)

`endif

/* hw/level_sync2.v */
// Two-flop synchroniser for a group of levels
`timescale 1ns/1ps
module level_sync2 #(
    parameter WIDTH = 1
) (
    input  wire             ref_clk,
    input  wire             srst,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    // ****************************************************************
    // Synchroniser stages
    // ****************************************************************
    always @(posedge ref_clk) begin
        if (srst) begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule // level_sync2

/* hw/system_oscillator_select.v */
// System oscillator enable, select, switchover and divider control
`timescale 1ns/1ps
`include "osc_select_map.vh"
module system_oscillator_select (
    input  wire        ref_clk,
    input  wire        srst,
    input  wire        soft_rst,
    input  wire        periph_rst,
    input  wire [3:0]  addr,
    input  wire [31:0] wr_data,
    input  wire        wr_en,
    input  wire        rd_en,
    output reg  [31:0] rd_data,
    input  wire        iso_ready,
    input  wire        ipo_ready,
    input  wire        ebo_ready,
    input  wire        rtco_ready,
    input  wire        nro_ready,
    input  wire        bro_ready,
    input  wire        pll_locked,
    input  wire        rtc_enabled,
    input  wire        low_power_state,
    output reg         iso_osc_en,
    output reg         ipo_osc_en,
    output reg         ebo_osc_en,
    output reg         rtco_osc_en,
    output reg         nro_osc_en,
    output reg         pll_osc_en,
    output reg         pll_double_en,
    output reg  [1:0]  nro_freq_sel,
    output reg  [2:0]  osc_mux_sel,
    output reg         osc_mux_gate,
    output reg  [2:0]  system_clock_div,
    output reg  [3:0]  periph_clock_div
);

    localparam [2:0] ST_IDLE   = 3'h0;
    localparam [2:0] ST_OFF    = 3'h1;
    localparam [2:0] ST_SWAP   = 3'h2;
    localparam [2:0] ST_WAIT   = 3'h3;
    localparam [2:0] ST_ON     = 3'h4;
    localparam [31:0] SETTLE_W = `OSC_SETTLE_CYC;
    localparam [3:0] SETTLE    = SETTLE_W[3:0];

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function src_ready;
        input [2:0] sel;
        input [7:0] rdy;
        begin
            src_ready = rdy[sel];
        end
    endfunction

    function [3:0] settle_next;
        input [3:0] cnt;
        begin
            settle_next = (cnt == 4'h0) ? 4'h0 : cnt - 4'h1;
        end
    endfunction

    function reg_hit;
        input [3:0] a;
        input [3:0] off;
        begin
            reg_hit = (a == off);
        end
    endfunction

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    wire [8:0] sync_w;

    level_sync2 #(
        .WIDTH (9)
    ) u_sync (
        .ref_clk  (ref_clk),
        .srst     (srst),
        .async_in ({low_power_state, rtc_enabled, pll_locked, bro_ready, nro_ready,
                    rtco_ready, ebo_ready, ipo_ready, iso_ready}),
        .sync_out (sync_w)
    );

    wire iso_rdy_s  = sync_w[0];
    wire ipo_rdy_s  = sync_w[1];
    wire ebo_rdy_s  = sync_w[2];
    wire rtco_rdy_s = sync_w[3];
    wire nro_rdy_s  = sync_w[4];
    wire bro_rdy_s  = sync_w[5];
    wire pll_rdy_s  = sync_w[6];
    wire rtc_en_s   = sync_w[7];
    wire lps_s      = sync_w[8];

    // Ready by select code; the pin clock is taken as running
    wire [7:0] rdy_vec = {1'b1, rtco_rdy_s, bro_rdy_s, ipo_rdy_s,
                          nro_rdy_s, ebo_rdy_s, pll_rdy_s, iso_rdy_s};

    // ****************************************************************
    // Registers
    // ****************************************************************
    reg        iso_en_q;
    reg        ipo_en_q;
    reg        ebo_en_q;
    reg        rtco_en_q;
    reg        pll_en_q;
    reg        dbl_sel_q;
    reg        ipo_off_q;
    reg [1:0]  nro_freq_q;
    reg [2:0]  sel_q;
    reg [2:0]  div_q;
    reg        done_q;
    reg [2:0]  state_q;
    reg [3:0]  cnt_q;

    // ****************************************************************
    // Write decode
    // ****************************************************************
    wire wr_clk  = wr_en && reg_hit(addr, `OSC_REG_CLKCTRL);
    wire wr_pll  = wr_en && reg_hit(addr, `OSC_REG_PLLCTRL);
    wire wr_pm   = wr_en && reg_hit(addr, `OSC_REG_PMCTRL);
    wire wr_nro  = wr_en && reg_hit(addr, `OSC_REG_NROCTRL);
    wire any_rst = soft_rst || periph_rst;

    // Oscillator enables and select: only srst restores them
    always @(posedge ref_clk) begin
        if (srst) begin
            iso_en_q  <= 1'b1;
            ipo_en_q  <= 1'b0;
            ebo_en_q  <= 1'b0;
            rtco_en_q <= 1'b0;
            pll_en_q  <= 1'b0;
            sel_q     <= `RST_SEL;
        end else begin
            if (wr_clk) begin
                iso_en_q  <= wr_data[`CLK_ISO_EN_BIT];
                ipo_en_q  <= wr_data[`CLK_IPO_EN_BIT];
                ebo_en_q  <= wr_data[`CLK_EBO_EN_BIT];
                rtco_en_q <= wr_data[`CLK_RTCO_EN_BIT];
                sel_q     <= wr_data[`CLK_SEL_LSB +: 3];
            end
            if (wr_pll) begin
                pll_en_q <= wr_data[`PLL_EN_BIT];
            end
        end
    end

    // Divider, low-power and rate controls
    always @(posedge ref_clk) begin
        if (srst) begin
            div_q      <= `RST_DIV;
            dbl_sel_q  <= 1'b0;
            ipo_off_q  <= 1'b0;
            nro_freq_q <= `RST_NRO_FREQ;
        end else if (any_rst) begin
            div_q     <= `RST_DIV;
            dbl_sel_q <= 1'b0;
            ipo_off_q <= 1'b0;
        end else begin
            if (wr_clk) begin
                div_q <= wr_data[`CLK_DIV_LSB +: 3];
            end
            if (wr_pll) begin
                dbl_sel_q <= wr_data[`PLL_DBL_SEL_BIT];
            end
            if (wr_pm) begin
                ipo_off_q <= wr_data[`PM_IPO_OFF_BIT];
            end
            if (wr_nro && (wr_data[`NRO_FREQ_LSB +: 2] <= `NRO_FREQ_30K)) begin
                nro_freq_q <= wr_data[`NRO_FREQ_LSB +: 2];
            end
        end
    end

    // ****************************************************************
    // Switchover sequence
    // ****************************************************************
    always @(posedge ref_clk) begin
        if (srst) begin
            state_q      <= ST_IDLE;
            cnt_q        <= 4'h0;
            done_q       <= 1'b1;
            osc_mux_sel  <= `RST_SEL;
            osc_mux_gate <= 1'b1;
        end else if (wr_clk) begin
            state_q      <= ST_OFF;
            cnt_q        <= SETTLE;
            done_q       <= 1'b0;
            osc_mux_gate <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    cnt_q <= 4'h0;
                end
                ST_OFF: begin
                    cnt_q <= settle_next(cnt_q);
                    if (cnt_q == 4'h0) begin
                        state_q <= ST_SWAP;
                    end
                end
                ST_SWAP: begin
                    osc_mux_sel <= sel_q;
                    state_q     <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (src_ready(osc_mux_sel, rdy_vec)) begin
                        cnt_q   <= SETTLE;
                        state_q <= ST_ON;
                    end
                end
                ST_ON: begin
                    cnt_q <= settle_next(cnt_q);
                    if (cnt_q == 4'h0) begin
                        osc_mux_gate <= 1'b1;
                        done_q       <= 1'b1;
                        state_q      <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Oscillator and clock outputs
    // ****************************************************************
    always @(posedge ref_clk) begin
        if (srst) begin
            iso_osc_en       <= 1'b1;
            ipo_osc_en       <= 1'b0;
            ebo_osc_en       <= 1'b0;
            rtco_osc_en      <= 1'b0;
            nro_osc_en       <= 1'b1;
            pll_osc_en       <= 1'b0;
            pll_double_en    <= 1'b0;
            nro_freq_sel     <= `RST_NRO_FREQ;
            system_clock_div <= `RST_DIV;
            periph_clock_div <= 4'h1;
        end else begin
            iso_osc_en       <= iso_en_q;
            ipo_osc_en       <= ipo_en_q && !(ipo_off_q && lps_s);
            ebo_osc_en       <= ebo_en_q || pll_en_q;
            rtco_osc_en      <= rtco_en_q || rtc_en_s;
            nro_osc_en       <= 1'b1;
            pll_osc_en       <= pll_en_q;
            pll_double_en    <= pll_en_q && dbl_sel_q;
            nro_freq_sel     <= nro_freq_q;
            system_clock_div <= div_q;
            periph_clock_div <= {1'b0, div_q} + 4'h1;
        end
    end

    // ****************************************************************
    // Read port
    // ****************************************************************
    reg [31:0] rd_d;

    always @* begin
        rd_d = 32'h0000_0000;
        case (addr)
            `OSC_REG_CLKCTRL: begin
                rd_d[`CLK_SEL_LSB +: 3]   = sel_q;
                rd_d[`CLK_DIV_LSB +: 3]   = div_q;
                rd_d[`CLK_DONE_BIT]       = done_q;
                rd_d[`CLK_ISO_EN_BIT]     = iso_en_q;
                rd_d[`CLK_IPO_EN_BIT]     = ipo_en_q;
                rd_d[`CLK_EBO_EN_BIT]     = ebo_en_q;
                rd_d[`CLK_RTCO_EN_BIT]    = rtco_en_q;
                rd_d[`CLK_ISO_RDY_BIT]    = iso_rdy_s;
                rd_d[`CLK_IPO_RDY_BIT]    = ipo_rdy_s;
                rd_d[`CLK_EBO_RDY_BIT]    = ebo_rdy_s;
                rd_d[`CLK_RTCO_RDY_BIT]   = rtco_rdy_s;
                rd_d[`CLK_NRO_RDY_BIT]    = nro_rdy_s;
                rd_d[`CLK_BRO_RDY_BIT]    = bro_rdy_s;
            end
            `OSC_REG_PLLCTRL: begin
                rd_d[`PLL_EN_BIT]         = pll_en_q;
                rd_d[`PLL_DBL_SEL_BIT]    = dbl_sel_q;
                rd_d[`PLL_RDY_BIT]        = pll_rdy_s;
            end
            `OSC_REG_PMCTRL: begin
                rd_d[`PM_IPO_OFF_BIT]     = ipo_off_q;
            end
            `OSC_REG_NROCTRL: begin
                rd_d[`NRO_FREQ_LSB +: 2]  = nro_freq_q;
            end
            default: begin
                rd_d = 32'h0000_0000;
            end
        endcase
    end

    always @(posedge ref_clk) begin
        if (srst) begin
            rd_data <= 32'h0000_0000;
        end else if (rd_en) begin
            rd_data <= rd_d;
        end else begin
            rd_data <= 32'h0000_0000;
        end
    end

endmodule // system_oscillator_select

/* verif/osc_select_sva.sv */
// Concurrent assertions for the system oscillator select block
`timescale 1ns/1ps
module osc_select_sva (
    input wire       ref_clk,
    input wire       srst,
    input wire [3:0] addr,
    input wire       wr_en,
    input wire       rtc_enabled,
    input wire       iso_osc_en,
    input wire       ipo_osc_en,
    input wire       ebo_osc_en,
    input wire       rtco_osc_en,
    input wire       nro_osc_en,
    input wire       pll_osc_en,
    input wire [1:0] nro_freq_sel,
    input wire [2:0] osc_mux_sel,
    input wire       osc_mux_gate,
    input wire [2:0] system_clock_div,
    input wire [3:0] periph_clock_div
);
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    nro_always_a: assert property (nro_osc_en)
        else $error("nano-ring enable dropped");
    rst_default_a: assert property ($fell(srst) |-> iso_osc_en && !ipo_osc_en && !rtco_osc_en
        && !pll_osc_en && osc_mux_sel == 3'h0 && nro_freq_sel == 2'h2 && osc_mux_gate)
        else $error("reset defaults wrong");
    rtc_force_a: assert property (rtc_enabled [*4] |-> rtco_osc_en)
        else $error("rtc oscillator not forced on");
    pll_base_a: assert property (pll_osc_en && $past(pll_osc_en) |-> ebo_osc_en)
        else $error("base oscillator off under pll");
    div_pair_a: assert property (periph_clock_div == system_clock_div + 4'h1)
        else $error("peripheral divider not half");
    wr_gate_a: assert property (wr_en && addr == 4'h0 |=> !osc_mux_gate)
        else $error("gate still open after select write");
    gate_hold_a: assert property ($fell(osc_mux_gate) |-> !osc_mux_gate [*6])
        else $error("gate reopened too soon");
    sel_quiet_a: assert property ($changed(osc_mux_sel) |-> !osc_mux_gate && !$past(osc_mux_gate))
        else $error("mux moved with gate open");
    sel_settle_a: assert property ($changed(osc_mux_sel) |=> !osc_mux_gate [*4])
        else $error("gate opened before settle");
    nro_wr_a: assert property ($changed(nro_freq_sel) |-> $past(wr_en && addr == 4'hC, 2))
        else $error("rate changed without write");

    switch_cv: cover property ($rose(osc_mux_gate));
    rtc_cv: cover property (rtc_enabled && rtco_osc_en);
    pll_cv: cover property (pll_osc_en && ebo_osc_en);
endmodule // osc_select_sva

bind system_oscillator_select osc_select_sva i_sva (.ref_clk, .srst, .addr, .wr_en, .rtc_enabled, .iso_osc_en,
    .ipo_osc_en, .ebo_osc_en, .rtco_osc_en, .nro_osc_en, .pll_osc_en, .nro_freq_sel, .osc_mux_sel, .osc_mux_gate,
    .system_clock_div, .periph_clock_div);

/* verif/system_oscillator_select_tb.sv */
// Self-checking testbench for the system oscillator select block
`timescale 1ns/1ps
`include "osc_select_map.vh"
module system_oscillator_select_tb;
    reg         ref_clk, srst, soft_rst, periph_rst, wr_en, rd_en;
    reg  [3:0]  addr, en4;
    reg  [31:0] wr_data, rv, r;
    reg         iso_ready, ipo_ready, ebo_ready, rtco_ready, nro_ready, bro_ready, pll_locked;
    reg         rtc_enabled, low_power_state;
    reg  [2:0]  c, d;
    reg  [1:0]  ef;
    integer     err_total, tests_run, i, m_sel, m_div;
    wire [31:0] rd_data;
    wire        iso_osc_en, ipo_osc_en, ebo_osc_en, rtco_osc_en, nro_osc_en, pll_osc_en, pll_double_en;
    wire        osc_mux_gate;
    wire [1:0]  nro_freq_sel;
    wire [2:0]  osc_mux_sel, system_clock_div;
    wire [3:0]  periph_clock_div;

    system_oscillator_select i_dut (.ref_clk, .srst, .soft_rst, .periph_rst, .addr, .wr_data, .wr_en, .rd_en,
        .rd_data, .iso_ready, .ipo_ready, .ebo_ready, .rtco_ready, .nro_ready, .bro_ready, .pll_locked,
        .rtc_enabled, .low_power_state, .iso_osc_en, .ipo_osc_en, .ebo_osc_en, .rtco_osc_en, .nro_osc_en,
        .pll_osc_en, .pll_double_en, .nro_freq_sel, .osc_mux_sel, .osc_mux_gate, .system_clock_div,
        .periph_clock_div);

    // ****************************************************************
    // Clock and tasks
    // ****************************************************************
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task chk(input [31:0] got, input [31:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task final_report;
        $display("checks=%0d mismatches=%0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task wr(input [3:0] a, input [31:0] v);
        addr <= a;
        wr_data <= v;
        wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
        @(posedge ref_clk);
    endtask

    task rd(input [3:0] a);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1 rv = rd_data;
        @(posedge ref_clk);
    endtask

    task sw(input [2:0] s, input [2:0] dv);
        m_sel = s;
        m_div = dv;
        wr(4'h0, {12'h000, en4, 10'h000, dv, s});
        rd(4'h0);
        chk(rv[6], 1'b0);
    endtask

    task wait_done;
        integer n;
        n = 0;
        rd(4'h0);
        while (rv[6] !== 1'b1 && n < 40) begin
            rd(4'h0);
            n = n + 1;
        end
        if (rv[6] !== 1'b1) begin
            err_total = err_total + 1;
            final_report;
        end
    endtask

    task dflt;
        chk(iso_osc_en, 1'b1);
        chk(osc_mux_sel, `SEL_ISO);
        chk(rtco_osc_en, 1'b0);
        chk(ipo_osc_en | pll_osc_en, 1'b0);
        chk(nro_freq_sel, `NRO_FREQ_30K);
        chk(nro_osc_en, 1'b1);
        rd(4'h0);
        chk(rv[19:16], 4'h1);
        chk(rv[6], 1'b1);
        rd(4'hC);
        chk(rv[1:0], `NRO_FREQ_30K);
        $display("test defaults done");
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        err_total = 0;
        tests_run = 0;
        void'($urandom(12220));
        srst <= 1'b1;
        {soft_rst, periph_rst, wr_en, rd_en, addr, wr_data} <= 40'h0;
        {iso_ready, ebo_ready, rtco_ready, nro_ready, bro_ready, pll_locked} <= 6'h3F;
        {ipo_ready, rtc_enabled, low_power_state} <= 3'h0;
        repeat (16) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        dflt;
        rd(4'h2);
        chk(rv, 32'h0);
        wr(4'h6, 32'hFFFFFFFF);
        chk(osc_mux_sel, `SEL_ISO);
        ef = `NRO_FREQ_30K;
        for (i = 0; i < 4; i = i + 1) begin
            wr(4'hC, i);
            if (i < 3)
                ef = i[1:0];
            rd(4'hC);
            chk(rv[1:0], ef);
            chk(nro_freq_sel, ef);
        end
        $display("test nro rate done");
        wr(4'h4, 32'h3);
        rd(4'h0);
        chk(pll_osc_en, 1'b1);
        chk(pll_double_en, 1'b1);
        chk(ebo_osc_en, 1'b1);
        chk(rv[18], 1'b0);
        rd(4'h4);
        chk(rv[8], 1'b1);
        $display("test pll done");
        en4 = 4'hF;
        sw(`SEL_IPO, 3'h0);
        repeat (20) @(posedge ref_clk);
        chk(osc_mux_gate, 1'b0);
        ipo_ready <= 1'b1;
        wait_done;
        chk(osc_mux_sel, `SEL_IPO);
        $display("test stalled switch done");
        for (i = 0; i < 8; i = i + 1) begin
            c = i[2:0];
            r = $urandom;
            d = r[2:0];
            sw(c, d);
            wait_done;
            chk(osc_mux_sel, m_sel);
            chk(osc_mux_gate, 1'b1);
            chk(system_clock_div, m_div);
            chk(periph_clock_div, m_div + 1);
            chk(rv[5:0], {d, c});
        end
        $display("test select codes done");
        wr(4'h8, 32'h1);
        low_power_state <= 1'b1;
        repeat (5) @(posedge ref_clk);
        chk(ipo_osc_en, 1'b0);
        low_power_state <= 1'b0;
        repeat (5) @(posedge ref_clk);
        chk(ipo_osc_en, 1'b1);
        $display("test low power done");
        for (i = 0; i < 2; i = i + 1) begin
            wr(4'h4, 32'h3);
            wr(4'h8, 32'h1);
            if (i == 0)
                soft_rst <= 1'b1;
            else
                periph_rst <= 1'b1;
            @(posedge ref_clk);
            {soft_rst, periph_rst} <= 2'h0;
            repeat (2) @(posedge ref_clk);
            chk(system_clock_div, 3'h0);
            chk(pll_double_en, 1'b0);
            chk({pll_osc_en, ipo_osc_en, osc_mux_sel}, {2'h3, `SEL_PIN});
            rd(4'h8);
            chk(rv[0], 1'b0);
        end
        $display("test soft reset done");
        en4 = 4'h7;
        sw(`SEL_ISO, 3'h0);
        wait_done;
        chk(rtco_osc_en, 1'b0);
        rtc_enabled <= 1'b1;
        repeat (5) @(posedge ref_clk);
        chk(rtco_osc_en, 1'b1);
        rtc_enabled <= 1'b0;
        $display("test rtc done");
        srst <= 1'b1;
        repeat (4) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        dflt;
        final_report;
    end
endmodule // system_oscillator_select_tb
